// *** logic/fpd_datapath.sv ***
// module: datapath end with multiplier, alu and three optional register levels
`timescale 1ns/1ps
`default_nettype none
module fpd_datapath (
	input wire logic ref_clk,
	input wire logic reset,
	fpd_if.dev bus
);
	// stage word: operands, instruction and valid travel together
	typedef struct packed {
		logic [31:0] a;
		logic [31:0] b;
		fpd_pkg::fpd_sel_t sel;
		logic [3:0] mop;
		logic [3:0] aop;
		logic vld;
	} fpd_stage_t;

	// pipeline word: product plus the alu operands and opcode of the same instruction
	typedef struct packed {
		logic [31:0] prod;
		logic [31:0] a;
		logic [31:0] b;
		logic [3:0] aop;
		fpd_pkg::fpd_sel_t sel;
		logic vld;
	} fpd_pipe_t;

	typedef struct packed {
		logic [31:0] prod;
		logic [31:0] sum;
		fpd_pkg::fpd_sel_t sel;
		logic vld;
	} fpd_res_t;

	// ========================================
	// arithmetic functions

	// signed integer to single float, round to nearest even
	function automatic logic [31:0] fpd_i2f(input logic [31:0] v);
		logic sgn;
		logic [31:0] mag;
		logic [31:0] norm;
		logic [5:0] lz;
		logic [7:0] expo;
		logic [24:0] rman;
		logic [31:0] y;
		sgn = v[31];
		mag = sgn ? (~v + 32'h1) : v;
		lz = 6'h20;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) begin
				lz = 6'(31 - i);
			end
		end
		norm = mag << lz;
		expo = 8'h9e - {2'h0, lz};
		rman = {1'b0, norm[31:8]} + {24'h0, norm[7] & (norm[8] | (|norm[6:0]))};
		// rounding carried into a new leading one
		if (rman[24]) begin
			expo = expo + 8'h01;
			rman = rman >> 1;
		end
		y = (mag == 32'h0) ? 32'h0 : {sgn, expo, rman[22:0]};
		return y;
	endfunction

	// single float to signed integer, truncates toward zero, saturates
	function automatic logic [31:0] fpd_f2i(input logic [31:0] v);
		logic [31:0] mag;
		logic [31:0] y;
		mag = {1'b1, v[22:0], 8'h00};
		if (v[30:23] < 8'h7f) begin
			y = 32'h0;
		end else if (v[30:23] > 8'h9d) begin
			y = v[31] ? 32'h80000000 : 32'h7fffffff;
		end else begin
			mag = mag >> (8'h9e - v[30:23]);
			y = v[31] ? (~mag + 32'h1) : mag;
		end
		return y;
	endfunction

	function automatic logic [31:0] fpd_isqrt(input logic [31:0] v);
		logic [31:0] r;
		logic [31:0] rem;
		logic [31:0] bitv;
		r = 32'h0;
		rem = v;
		bitv = 32'h40000000;
		for (int i = 0; i < 16; i++) begin
			if (rem >= (r | bitv)) begin
				rem = rem - (r | bitv);
				r = (r >> 1) | bitv;
			end else begin
				r = r >> 1;
			end
			bitv = bitv >> 2;
		end
		return r;
	endfunction

	function automatic logic [31:0] fpd_mul_unit(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
		logic [31:0] y;
		y = 32'h0;
		case (op)
			fpd_pkg::MOP_MUL: y = $bits(y)'(a * b);
			fpd_pkg::MOP_DIV: y = (b == 32'h0) ? 32'hffffffff : a / b;
			fpd_pkg::MOP_SQRT: y = fpd_isqrt(a);
			default: y = 32'h0;
		endcase
		return y;
	endfunction

	function automatic logic [31:0] fpd_alu_unit(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] p, input logic [31:0] acc);
		logic [31:0] y;
		y = 32'h0;
		case (op)
			fpd_pkg::AOP_ADD: y = a + b;
			fpd_pkg::AOP_SUB: y = a - b;
			fpd_pkg::AOP_I2F: y = fpd_i2f(a);
			fpd_pkg::AOP_F2I: y = fpd_f2i(a);
			fpd_pkg::AOP_AND: y = a & b;
			fpd_pkg::AOP_OR: y = a | b;
			fpd_pkg::AOP_XOR: y = a ^ b;
			fpd_pkg::AOP_SHL: y = a << b[4:0];
			fpd_pkg::AOP_SHR: y = a >> b[4:0];
			fpd_pkg::AOP_MAC: y = p + acc;
			fpd_pkg::AOP_PASS: y = p;
			default: y = 32'h0;
		endcase
		return y;
	endfunction

	// ========================================
	// state
	fpd_stage_t in_q, in_d, in_eff;
	fpd_pipe_t pipe_q, pipe_d, pipe_eff;
	fpd_res_t out_q, out_d, out_eff;
	logic [31:0] acc_q, acc_d; // alu_feedback_register
	logic [31:0] prod_now, sum_now;
	logic [31:0] result_q, result_d;
	logic rvld_q, rvld_d;
	logic [2:0] psel;

	assign psel = bus.pipeline_level_select;

	// ========================================
	// combinational datapath
	always_comb begin
		in_d.a = bus.first_operand_bus;
		in_d.b = bus.second_operand_bus;
		in_d.sel = bus.unit_sel;
		in_d.mop = bus.mul_op;
		in_d.aop = bus.alu_op;
		in_d.vld = bus.instr_valid;
		in_eff = psel[fpd_pkg::PSEL_IN_BIT] ? in_d : in_q;
		prod_now = fpd_mul_unit(in_eff.mop, in_eff.a, in_eff.b);
		pipe_d.prod = prod_now;
		pipe_d.a = in_eff.a; // alu operands travel with the product
		pipe_d.b = in_eff.b;
		pipe_d.aop = in_eff.aop;
		pipe_d.sel = in_eff.sel;
		pipe_d.vld = in_eff.vld;
		pipe_eff = psel[fpd_pkg::PSEL_PIPE_BIT] ? pipe_d : pipe_q;
		sum_now = 32'h0;
		case (pipe_eff.sel)
			fpd_pkg::FPD_SEL_MUL: sum_now = pipe_eff.prod;
			fpd_pkg::FPD_SEL_ALU: sum_now = fpd_alu_unit(pipe_eff.aop, pipe_eff.a, pipe_eff.b, 32'h0, acc_q);
			fpd_pkg::FPD_SEL_CHAIN: sum_now = fpd_alu_unit(pipe_eff.aop, pipe_eff.a, pipe_eff.b, pipe_eff.prod, acc_q);
			fpd_pkg::FPD_SEL_INTDIV: sum_now = fpd_alu_unit(fpd_pkg::AOP_PASS, 32'h0, 32'h0, pipe_eff.prod, acc_q);
			default: sum_now = 32'h0;
		endcase
		acc_d = (pipe_eff.vld && pipe_eff.sel == fpd_pkg::FPD_SEL_CHAIN) ? sum_now : acc_q;
		out_d.prod = pipe_eff.prod;
		out_d.sum = sum_now;
		out_d.sel = pipe_eff.sel;
		out_d.vld = pipe_eff.vld;
		out_eff = psel[fpd_pkg::PSEL_OUT_BIT] ? out_d : out_q;
		// result bus holds the last result, feedback changes must not leak out
		result_d = out_eff.vld ? out_eff.sum : result_q;
		rvld_d = out_eff.vld;
	end

	// ========================================
	// register levels overlap instructions
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			in_q <= '0;
			pipe_q <= '0;
			out_q <= '0;
			acc_q <= fpd_pkg::DATA_RESET;
		end else begin
			in_q <= in_d;
			pipe_q <= pipe_d;
			out_q <= out_d;
			acc_q <= acc_d;
		end
	end

	// result word stage (one more flop so outputs come from registers)
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			result_q <= fpd_pkg::DATA_RESET;
			rvld_q <= 1'b0;
		end else begin
			result_q <= result_d;
			rvld_q <= rvld_d;
		end
	end

	assign bus.result_bus = result_q;
	assign bus.result_valid = rvld_q;
endmodule // fpd_datapath
`default_nettype wire

// *** logic/fpd_pkg.sv ***
// package: shared constants and types for the floating point datapath
`default_nettype none
package fpd_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned OP_W = 4;
	localparam int unsigned PSEL_W = 3;
	// pipeline_level_select bit positions, a low bit enables its level
	localparam int unsigned PSEL_IN_BIT = 0;
	localparam int unsigned PSEL_PIPE_BIT = 1;
	localparam int unsigned PSEL_OUT_BIT = 2;
	localparam logic [2:0] PSEL_RESET = 3'h0;
	localparam logic [31:0] DATA_RESET = 32'h0;
	// unit selection
	typedef enum logic [1:0] {
		FPD_SEL_MUL = 2'h0,
		FPD_SEL_ALU = 2'h1,
		FPD_SEL_CHAIN = 2'h2,
		FPD_SEL_INTDIV = 2'h3
	} fpd_sel_t;
	// multiplier operations
	localparam logic [3:0] MOP_MUL = 4'h0;
	localparam logic [3:0] MOP_DIV = 4'h1;
	localparam logic [3:0] MOP_SQRT = 4'h2;
	// alu operations
	localparam logic [3:0] AOP_ADD = 4'h0;
	localparam logic [3:0] AOP_SUB = 4'h1;
	localparam logic [3:0] AOP_I2F = 4'h2;
	localparam logic [3:0] AOP_F2I = 4'h3;
	localparam logic [3:0] AOP_AND = 4'h4;
	localparam logic [3:0] AOP_OR = 4'h5;
	localparam logic [3:0] AOP_XOR = 4'h6;
	localparam logic [3:0] AOP_SHL = 4'h7;
	localparam logic [3:0] AOP_SHR = 4'h8;
	localparam logic [3:0] AOP_MAC = 4'h9; // product plus fed-back sum
	localparam logic [3:0] AOP_PASS = 4'ha;
endpackage
`default_nettype wire

// *** logic/fpd_if.sv ***
// interface: controller to datapath instruction, operand and result wires
`timescale 1ns/1ps
`default_nettype none
interface fpd_if;
	logic [31:0] first_operand_bus;
	logic [31:0] second_operand_bus;
	logic [31:0] result_bus;
	logic [2:0] pipeline_level_select;
	fpd_pkg::fpd_sel_t unit_sel;
	logic [3:0] mul_op;
	logic [3:0] alu_op;
	logic instr_valid;
	logic result_valid;
	modport dev (
		input first_operand_bus, second_operand_bus, pipeline_level_select, unit_sel, mul_op, alu_op, instr_valid,
		output result_bus, result_valid
	);
	modport ctl (
		output first_operand_bus, second_operand_bus, pipeline_level_select, unit_sel, mul_op, alu_op, instr_valid,
		input result_bus, result_valid
	);
endinterface // fpd_if
`default_nettype wire

// *** logic/fpd_controller.sv ***
// module: controller end issuing instructions and collecting results
`timescale 1ns/1ps
`default_nettype none
module fpd_controller (
	input wire logic ref_clk,
	input wire logic reset,
	fpd_if.ctl bus,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [31:0] req_a,
	input wire logic [31:0] req_b,
	input wire logic [1:0] req_sel,
	input wire logic [3:0] req_mop,
	input wire logic [3:0] req_aop,
	input wire logic [2:0] req_psel,
	output logic rsp_valid,
	output logic [31:0] rsp_data
);
	typedef enum logic [1:0] {FPD_IDLE, FPD_WAIT} fpd_cst_t;
	fpd_cst_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [31:0] a_q, a_d, b_q, b_d;
	logic [1:0] sel_q, sel_d;
	logic [3:0] mop_q, mop_d, aop_q, aop_d;
	logic [2:0] psel_q, psel_d;
	logic iv_q, iv_d;
	logic rdy_q, rdy_d;
	logic rv_q, rv_d;
	logic [31:0] rd_q, rd_d;

	// latency of a select: one per enabled level plus the result flop
	function automatic logic [2:0] fpd_lat(input logic [2:0] p);
		return 3'h1 + {2'h0, ~p[0]} + {2'h0, ~p[1]} + {2'h0, ~p[2]};
	endfunction

	// ========================================
	// issue and wait sequencer
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		a_d = a_q;
		b_d = b_q;
		sel_d = sel_q;
		mop_d = mop_q;
		aop_d = aop_q;
		psel_d = psel_q;
		iv_d = 1'b0;
		rdy_d = 1'b0;
		rv_d = 1'b0;
		rd_d = rd_q;
		case (st_q)
			FPD_IDLE: begin
				rdy_d = 1'b1;
				if (req_valid && rdy_q) begin
					a_d = req_a;
					b_d = req_b;
					sel_d = req_sel;
					mop_d = req_mop;
					aop_d = req_aop;
					psel_d = (req_sel != 2'h1 && req_mop != fpd_pkg::MOP_MUL) ? (req_psel & 3'h6) : req_psel;
					iv_d = 1'b1;
					rdy_d = 1'b0;
					cnt_d = fpd_lat(psel_d);
					st_d = FPD_WAIT;
				end
			end
			FPD_WAIT: begin
				if (bus.result_valid) begin
					rv_d = 1'b1;
					rd_d = bus.result_bus;
				end
				if (cnt_q == 3'h0) begin
					st_d = FPD_IDLE;
				end else begin
					cnt_d = cnt_q - 3'h1;
				end
			end
			default: st_d = FPD_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_q <= FPD_IDLE;
			cnt_q <= 3'h0;
			a_q <= fpd_pkg::DATA_RESET;
			b_q <= fpd_pkg::DATA_RESET;
			sel_q <= 2'h0;
			mop_q <= 4'h0;
			aop_q <= 4'h0;
			psel_q <= fpd_pkg::PSEL_RESET;
			iv_q <= 1'b0;
			rdy_q <= 1'b0;
			rv_q <= 1'b0;
			rd_q <= fpd_pkg::DATA_RESET;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			a_q <= a_d;
			b_q <= b_d;
			sel_q <= sel_d;
			mop_q <= mop_d;
			aop_q <= aop_d;
			psel_q <= psel_d;
			iv_q <= iv_d;
			rdy_q <= rdy_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
		end
	end

	// ========================================
	// drive the link
	assign bus.first_operand_bus = a_q;
	assign bus.second_operand_bus = b_q;
	assign bus.unit_sel = fpd_pkg::fpd_sel_t'(sel_q);
	assign bus.mul_op = mop_q;
	assign bus.alu_op = aop_q;
	assign bus.pipeline_level_select = psel_q;
	assign bus.instr_valid = iv_q;
	assign req_ready = rdy_q;
	assign rsp_valid = rv_q;
	assign rsp_data = rd_q;
endmodule // fpd_controller
`default_nettype wire

// *** dv/fpd_assertions.sv ***
// file: interface checker for the controller and datapath pair
`timescale 1ns/1ps
`default_nettype none
module fpd_assertions (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [31:0] first_operand_bus,
	input wire logic [31:0] second_operand_bus,
	input wire logic [31:0] result_bus,
	input wire logic [2:0] pipeline_level_select,
	input wire fpd_pkg::fpd_sel_t unit_sel,
	input wire logic [3:0] mul_op,
	input wire logic [3:0] alu_op,
	input wire logic instr_valid,
	input wire logic result_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ==========================================
	// level count, a low select bit enables one level
	logic [1:0] lvl;
	assign lvl = {1'b0, ~pipeline_level_select[0]} + {1'b0, ~pipeline_level_select[1]}
		+ {1'b0, ~pipeline_level_select[2]};
	// ==========================================
	// latency per enabled level count
	property p_lat0; instr_valid && lvl == 2'h0 |=> result_valid; endproperty
	a_lat0: assert property (p_lat0) else $error("flowthrough result not one edge later");
	property p_lat1; instr_valid && lvl == 2'h1 |-> ##2 result_valid; endproperty
	a_lat1: assert property (p_lat1) else $error("one level result not two edges later");
	property p_lat2; instr_valid && lvl == 2'h2 |-> ##3 result_valid; endproperty
	a_lat2: assert property (p_lat2) else $error("two level result not three edges later");
	property p_lat3; instr_valid && lvl == 2'h3 |-> ##4 result_valid; endproperty
	a_lat3: assert property (p_lat3) else $error("full pipeline result not four edges later");
	property p_cause; result_valid && lvl == 2'h0 |-> $past(instr_valid); endproperty
	a_cause: assert property (p_cause) else $error("flowthrough result without instruction");
	property p_divin;
		instr_valid && unit_sel != fpd_pkg::FPD_SEL_ALU && mul_op != fpd_pkg::MOP_MUL |-> !pipeline_level_select[0];
	endproperty
	a_divin: assert property (p_divin) else $error("divide or root issued with input level bypassed");
	// ==========================================
	// result values and holding
	property p_mul;
		instr_valid && lvl == 2'h0 && unit_sel == fpd_pkg::FPD_SEL_MUL && mul_op == fpd_pkg::MOP_MUL
		|=> result_bus == 32'($past(first_operand_bus) * $past(second_operand_bus));
	endproperty
	a_mul: assert property (p_mul) else $error("product wrong");
	property p_add;
		instr_valid && pipeline_level_select == 3'h3 && unit_sel == fpd_pkg::FPD_SEL_ALU
		&& alu_op == fpd_pkg::AOP_ADD
		|-> ##2 result_bus == 32'($past(first_operand_bus, 2) + $past(second_operand_bus, 2));
	endproperty
	a_add: assert property (p_add) else $error("registered sum wrong");
	property p_hold; !result_valid |-> $stable(result_bus); endproperty
	a_hold: assert property (p_hold) else $error("result bus moved without result");
	c_full: cover property (instr_valid && lvl == 2'h3);
	c_flow: cover property (instr_valid && lvl == 2'h0);
	c_chain: cover property (instr_valid && unit_sel == fpd_pkg::FPD_SEL_CHAIN);
endmodule // fpd_assertions
`default_nettype wire

// *** dv/tb.sv ***
// file: testbench driving the controller end against the datapath end
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {
		logic [31:0] a, b;
		logic [1:0] sel;
		logic [3:0] mop, aop;
		logic [2:0] psel;
		logic [31:0] exp;
	} fpd_row_t;
	logic ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_ready, rsp_valid;
	logic [31:0] req_a = 32'h0, req_b = 32'h0, rsp_data;
	logic [1:0] req_sel = 2'h0;
	logic [3:0] req_mop = 4'h0, req_aop = 4'h0;
	logic [2:0] req_psel = 3'h7;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	fpd_row_t rows [13] = '{
		'{32'h6, 32'h7, 2'h0, fpd_pkg::MOP_MUL, 4'h0, 3'h7, 32'h2a},
		'{32'h64, 32'h7, 2'h0, fpd_pkg::MOP_DIV, 4'h0, 3'h6, 32'he},
		'{32'h90, 32'h0, 2'h0, fpd_pkg::MOP_SQRT, 4'h0, 3'h5, 32'hc},
		'{32'h5, 32'h9, 2'h1, 4'h0, fpd_pkg::AOP_ADD, 3'h3, 32'he},
		'{32'h9, 32'h5, 2'h1, 4'h0, fpd_pkg::AOP_SUB, 3'h4, 32'h4},
		'{32'hf0, 32'h3c, 2'h1, 4'h0, fpd_pkg::AOP_AND, 3'h2, 32'h30},
		'{32'hf0, 32'h3c, 2'h1, 4'h0, fpd_pkg::AOP_OR, 3'h1, 32'hfc},
		'{32'hf0, 32'h3c, 2'h1, 4'h0, fpd_pkg::AOP_XOR, 3'h0, 32'hcc},
		'{32'h1, 32'h4, 2'h1, 4'h0, fpd_pkg::AOP_SHL, 3'h7, 32'h10},
		'{32'h100, 32'h4, 2'h1, 4'h0, fpd_pkg::AOP_SHR, 3'h0, 32'h10},
		'{32'h3, 32'h0, 2'h1, 4'h0, fpd_pkg::AOP_I2F, 3'h6, 32'h40400000},
		'{32'h40a00000, 32'h0, 2'h1, 4'h0, fpd_pkg::AOP_F2I, 3'h5, 32'h5},
		'{32'h64, 32'h7, 2'h3, fpd_pkg::MOP_DIV, fpd_pkg::AOP_PASS, 3'h0, 32'he}
	};
	// ==========================================
	// clock, design ends and checker
	always #5 ref_clk = ~ref_clk;
	fpd_if u_fpd_if ();
	fpd_datapath u_fpd_datapath (.ref_clk, .reset, .bus(u_fpd_if));
	fpd_controller u_fpd_controller (.ref_clk, .reset, .bus(u_fpd_if), .req_valid, .req_ready, .req_a, .req_b,
		.req_sel, .req_mop, .req_aop, .req_psel, .rsp_valid, .rsp_data);
	fpd_assertions u_fpd_assertions (.ref_clk, .reset, .first_operand_bus(u_fpd_if.first_operand_bus),
		.second_operand_bus(u_fpd_if.second_operand_bus), .result_bus(u_fpd_if.result_bus),
		.pipeline_level_select(u_fpd_if.pipeline_level_select), .unit_sel(u_fpd_if.unit_sel),
		.mul_op(u_fpd_if.mul_op), .alu_op(u_fpd_if.alu_op), .instr_valid(u_fpd_if.instr_valid),
		.result_valid(u_fpd_if.result_valid));
	// ==========================================
	// compare, verdict and one request
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic run_op(input fpd_row_t r);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		{req_a, req_b, req_sel, req_mop, req_aop, req_psel} = {r.a, r.b, r.sel, r.mop, r.aop, r.psel};
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		check_word("rsp_valid", 32'h1, {31'h0, rsp_valid});
		check_word("result", r.exp, rsp_data);
	endtask
	// ==========================================
	// cycle ceiling against hangs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(negedge ref_clk);
		reset = 1'b0;
		@(negedge ref_clk);
		foreach (rows[i]) run_op(rows[i]);
		// second reset in mid-run clears the held result
		reset = 1'b1;
		@(negedge ref_clk);
		check_word("reset rsp_data", 32'h0, rsp_data);
		check_word("reset rsp_valid", 32'h0, {31'h0, rsp_valid});
		check_word("reset req_ready", 32'h0, {31'h0, req_ready});
		check_word("reset result_bus", 32'h0, u_fpd_if.result_bus);
		reset = 1'b0;
		@(negedge ref_clk);
		// accumulate chain from a cleared feedback value
		run_op('{32'h2, 32'h3, 2'h2, fpd_pkg::MOP_MUL, fpd_pkg::AOP_MAC, 3'h0, 32'h6});
		run_op('{32'h4, 32'h5, 2'h2, fpd_pkg::MOP_MUL, fpd_pkg::AOP_MAC, 3'h0, 32'h1a});
		run_op('{32'h1, 32'h1, 2'h2, fpd_pkg::MOP_MUL, fpd_pkg::AOP_MAC, 3'h7, 32'h1b});
		print_verdict();
	end
endmodule // tb
`default_nettype wire
